// ---- design/stc_pkg.sv ----
// Purpose: Shared constants and types for the shared time stamp counter block.
// Assumes: One core clock at 250 MHz; core count fixed at build time.
// Notes:   Counts, field positions and reset values are named here only.
package stc_pkg;

  // ==========================================================================
  // Sizes
  localparam int STC_CORES  = 4;
  localparam int STC_CNT_W  = 64;
  localparam int STC_HALF_W = 32;
  localparam int STC_ID_W   = 8;

  // ==========================================================================
  // Field positions and reset values
  localparam int                   STC_CAP_INVARIANT_BIT = 8;
  localparam logic [STC_CNT_W-1:0] STC_CNT_RST           = 64'h0;
  localparam logic [STC_ID_W-1:0]  STC_CORE_ID_BASE      = 8'h00;

  // ==========================================================================
  // Timing
  localparam int STC_CLK_PERIOD_NS = 4;
  localparam int STC_REF_PERIOD_NS = 100;
  localparam int STC_REF_DIV_CYC   = (STC_REF_PERIOD_NS + STC_CLK_PERIOD_NS - 1)
                                     / STC_CLK_PERIOD_NS;
  localparam int STC_DIV_W         = $clog2(STC_REF_DIV_CYC);

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    STC_KIND_UNORD = 2'h0,
    STC_KIND_ORD   = 2'h1,
    STC_KIND_CAP   = 2'h2
  } stc_kind_t;

  typedef enum logic [1:0] {
    STC_ST_IDLE   = 2'h0,
    STC_ST_RETIRE = 2'h1,
    STC_ST_TICK   = 2'h3
  } stc_state_t;

  typedef struct packed {
    logic      valid;
    stc_kind_t kind;
  } stc_req_t;

  typedef struct packed {
    logic                 en;
    logic [STC_CNT_W-1:0] value;
  } stc_wr_t;

  typedef struct packed {
    logic                  valid;
    stc_kind_t             kind;
    logic [STC_HALF_W-1:0] upper_result_reg;
    logic [STC_HALF_W-1:0] lower_result_reg;
    logic [STC_ID_W-1:0]   core_id;
  } stc_rsp_t;

  // Upper result of a capability query: only the invariant-counter flag is set.
  function automatic logic [STC_HALF_W-1:0] stc_cap_upper();
    logic [STC_HALF_W-1:0] v;
    v = 32'h0;
    v[STC_CAP_INVARIANT_BIT] = 1'b1;
    return v;
  endfunction

endpackage

// ---- design/stc_rate_div.sv ----
// Purpose: Shared increment enable for every per-core counter.
// Assumes: Core clock is the highest performance-state frequency.
// Notes:   One enable feeds all counters so they can never drift apart.
`timescale 1ns/100ps
module stc_rate_div
  import stc_pkg::*;
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  // Control
  input  wire logic i_counter_freq_scale_select,
  // Enable out
  output logic      o_tick
);

  logic [STC_DIV_W-1:0] div_ff;
  logic [STC_DIV_W-1:0] nxt_div;
  logic                 tick_ff;
  logic                 nxt_tick;

  // ==========================================================================
  // Divider
  always_comb begin
    nxt_div  = div_ff;
    nxt_tick = 1'b0;
    if (i_counter_freq_scale_select) begin
      // Scaled to the core's top frequency: advance every cycle.
      nxt_div  = '0;
      nxt_tick = 1'b1;
    end else if (div_ff == STC_DIV_W'(STC_REF_DIV_CYC - 1)) begin
      nxt_div  = '0;
      nxt_tick = 1'b1;
    end else begin
      nxt_div = div_ff + STC_DIV_W'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;

endmodule

// ---- design/stc_top.sv ----
// Purpose: Per-core 64-bit time stamp counters with ordered and unordered reads.
// Assumes: Each core raises i_older_retired while nothing older is in flight.
// Notes:   One outstanding read per core; ready drops while a read is pending.
`timescale 1ns/100ps
module stc_top
  import stc_pkg::*;
(
  // Clock and reset
  input  wire logic     i_mclk,
  input  wire logic     i_reset_n,
  // Configuration, held in the hardware configuration register by firmware
  input  wire logic     i_counter_freq_scale_select,
  // Read requests from each core pipeline
  input  wire stc_req_t i_req           [STC_CORES],
  input  wire logic     i_older_retired [STC_CORES],
  output logic          o_req_ready     [STC_CORES],
  // Software counter loads
  input  wire stc_wr_t  i_wr            [STC_CORES],
  // Read answers
  output stc_rsp_t      o_rsp           [STC_CORES]
);

  // ==========================================================================
  // State
  logic                 tick;
  logic [STC_CNT_W-1:0] count_ff   [STC_CORES];
  logic [STC_CNT_W-1:0] nxt_count  [STC_CORES];
  logic                 fresh_ff   [STC_CORES];
  logic                 nxt_fresh  [STC_CORES];
  stc_state_t           state_ff   [STC_CORES];
  stc_state_t           nxt_state  [STC_CORES];
  stc_kind_t            kind_ff    [STC_CORES];
  stc_kind_t            nxt_kind   [STC_CORES];
  logic                 ready_ff   [STC_CORES];
  logic                 nxt_ready  [STC_CORES];
  stc_rsp_t             rsp_ff     [STC_CORES];
  stc_rsp_t             nxt_rsp    [STC_CORES];

  // ==========================================================================
  // Shared increment enable
  // The block has no knowledge of core power states, so nothing can gate it.
  stc_rate_div u_rate_div (
    .i_mclk                      (i_mclk),
    .i_reset_n                   (i_reset_n),
    .i_counter_freq_scale_select (i_counter_freq_scale_select),
    .o_tick                      (tick)
  );

  // Builds an answer carrying a sampled count.
  function automatic stc_rsp_t count_rsp(input stc_kind_t            kind,
                                         input logic [STC_CNT_W-1:0] value,
                                         input int                   core);
    stc_rsp_t r;
    r                  = '0;
    r.valid            = 1'b1;
    r.kind             = kind;
    r.upper_result_reg = value[STC_CNT_W-1:STC_HALF_W];
    r.lower_result_reg = value[STC_HALF_W-1:0];
    if (kind == STC_KIND_ORD) begin
      r.core_id = STC_CORE_ID_BASE + STC_ID_W'(core);
    end
    return r;
  endfunction

  // ==========================================================================
  // Counters
  always_comb begin
    for (int c = 0; c < STC_CORES; c++) begin
      if (i_wr[c].en) begin
        nxt_count[c] = i_wr[c].value;
      end else if (tick) begin
        // Natural overflow of the 64-bit sum wraps to zero.
        nxt_count[c] = count_ff[c] + STC_CNT_W'(1);
      end else begin
        nxt_count[c] = count_ff[c];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      for (int c = 0; c < STC_CORES; c++) begin
        count_ff[c] <= STC_CNT_RST;
      end
    end else begin
      for (int c = 0; c < STC_CORES; c++) begin
        count_ff[c] <= nxt_count[c];
      end
    end
  end

  // ==========================================================================
  // Read sequencing
  // A read at a slow rate may arrive before the count has moved since the
  // previous read; it is held until the next step rather than answered with a
  // repeat, trading latency for strictly increasing values.
  always_comb begin
    for (int c = 0; c < STC_CORES; c++) begin
      logic      sample;
      logic      take;
      stc_kind_t k;
      sample       = 1'b0;
      take         = i_req[c].valid && ready_ff[c];
      k            = take ? i_req[c].kind : kind_ff[c];
      nxt_state[c] = state_ff[c];
      nxt_kind[c]  = kind_ff[c];
      nxt_rsp[c]   = '0;
      unique case (state_ff[c])
        STC_ST_IDLE: begin
          if (take) begin
            nxt_kind[c] = k;
            if (k == STC_KIND_CAP) begin
              nxt_rsp[c].valid            = 1'b1;
              nxt_rsp[c].kind             = STC_KIND_CAP;
              nxt_rsp[c].upper_result_reg = stc_cap_upper();
            end else if (k == STC_KIND_ORD && !i_older_retired[c]) begin
              nxt_state[c] = STC_ST_RETIRE;
            end else if (!fresh_ff[c]) begin
              nxt_state[c] = STC_ST_TICK;
            end else begin
              sample = 1'b1;
            end
          end
        end
        STC_ST_RETIRE: begin
          if (i_older_retired[c]) begin
            if (fresh_ff[c]) begin
              sample       = 1'b1;
              nxt_state[c] = STC_ST_IDLE;
            end else begin
              nxt_state[c] = STC_ST_TICK;
            end
          end
        end
        STC_ST_TICK: begin
          if (fresh_ff[c]) begin
            sample       = 1'b1;
            nxt_state[c] = STC_ST_IDLE;
          end
        end
        default: begin
          nxt_state[c] = STC_ST_IDLE;
        end
      endcase
      if (sample) begin
        nxt_rsp[c] = count_rsp(k, count_ff[c], c);
      end
      // A new step or load arriving with a sample keeps the flag set.
      nxt_fresh[c] = (tick || i_wr[c].en) ? 1'b1 : (fresh_ff[c] && !sample);
      // One read in flight per core keeps answers in program order.
      nxt_ready[c] = (nxt_state[c] == STC_ST_IDLE);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      for (int c = 0; c < STC_CORES; c++) begin
        state_ff[c] <= STC_ST_IDLE;
        kind_ff[c]  <= STC_KIND_UNORD;
        fresh_ff[c] <= 1'b1;
        ready_ff[c] <= 1'b0;
        rsp_ff[c]   <= '0;
      end
    end else begin
      for (int c = 0; c < STC_CORES; c++) begin
        state_ff[c] <= nxt_state[c];
        kind_ff[c]  <= nxt_kind[c];
        fresh_ff[c] <= nxt_fresh[c];
        ready_ff[c] <= nxt_ready[c];
        rsp_ff[c]   <= nxt_rsp[c];
      end
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    for (int c = 0; c < STC_CORES; c++) begin
      o_req_ready[c] = ready_ff[c];
      o_rsp[c]       = rsp_ff[c];
    end
  end

endmodule

// ---- test/stc_top_asserts.sv ----
// Purpose: Port checks for the time stamp counter.
// Assumes: Only stc_top ports are seen.
// Notes:   Cores 0 and 1 are watched.
`timescale 1ns/100ps
module stc_top_asserts
  import stc_pkg::*;
(
  // Watched ports
  input wire logic     i_mclk,
  input wire logic     i_reset_n,
  input wire logic     i_counter_freq_scale_select,
  input wire stc_req_t i_req           [STC_CORES],
  input wire logic     i_older_retired [STC_CORES],
  input wire logic     o_req_ready     [STC_CORES],
  input wire stc_wr_t  i_wr            [STC_CORES],
  input wire stc_rsp_t o_rsp           [STC_CORES]
);
  // ==========================================================
  // Helpers
  logic [63:0] last_ff;
  logic        have_ff;
  logic        tk;
  stc_rsp_t    r0;
  assign tk = i_req[0].valid && o_req_ready[0];
  assign r0 = o_rsp[0];
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // A load may move the count down, so the order check restarts.
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || i_wr[0].en) begin
      have_ff <= 1'b0;
    end else if (r0.valid && r0.kind != STC_KIND_CAP) begin
      have_ff <= 1'b1;
      last_ff <= {r0.upper_result_reg, r0.lower_result_reg};
    end
  end
  property p_cap; tk && i_req[0].kind == STC_KIND_CAP |=> r0.valid
    && r0.upper_result_reg == 32'h100 && r0.lower_result_reg == 32'h0; endproperty
  a_cap: assert property (p_cap) else $error("cap answer");
  property p_ordw;
    tk && i_req[0].kind == STC_KIND_ORD && !i_older_retired[0] |=> !r0.valid;
  endproperty
  a_ordw: assert property (p_ordw) else $error("early ordered");
  property p_ordr; r0.valid && r0.kind == STC_KIND_ORD |-> $past(i_older_retired[0]); endproperty
  a_ordr: assert property (p_ordr) else $error("ordered unretired");
  property p_id1; o_rsp[1].valid && o_rsp[1].kind == STC_KIND_ORD |-> o_rsp[1].core_id == 8'h01;
  endproperty
  a_id1: assert property (p_id1) else $error("core id");
  property p_id0; r0.valid && r0.kind != STC_KIND_ORD |-> r0.core_id == 8'h00; endproperty
  a_id0: assert property (p_id0) else $error("core id zero");
  property p_rdy; tk |=> o_req_ready[0] == r0.valid; endproperty
  a_rdy: assert property (p_rdy) else $error("ready");
  // The step that keeps a back-to-back read fresh was launched two edges earlier.
  property p_fast; tk && i_req[0].kind == STC_KIND_UNORD && i_counter_freq_scale_select
    && $past(i_counter_freq_scale_select) && $past(i_counter_freq_scale_select, 2)
    |=> r0.valid; endproperty
  a_fast: assert property (p_fast) else $error("unordered late");
  property p_mono; r0.valid && r0.kind != STC_KIND_CAP && have_ff
    |-> {r0.upper_result_reg, r0.lower_result_reg} > last_ff; endproperty
  a_mono: assert property (p_mono) else $error("not increasing");
endmodule
bind stc_top stc_top_asserts chk_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_counter_freq_scale_select(i_counter_freq_scale_select), .i_req(i_req),
  .i_older_retired(i_older_retired), .o_req_ready(o_req_ready), .i_wr(i_wr), .o_rsp(o_rsp));

// ---- test/stc_core_model.sv ----
// Purpose: Core pipeline retirement model.
// Assumes: One ordered read in flight per core.
// Notes:   Older work stays in flight i_dly edges after a take.
`timescale 1ns/100ps
module stc_core_model
  import stc_pkg::*;
(
  // Pipeline view
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic [7:0] i_dly,
  input  wire stc_req_t   i_req     [STC_CORES],
  input  wire logic       i_ready   [STC_CORES],
  output logic            o_retired [STC_CORES]
);
  logic [7:0] cnt_ff [STC_CORES];
  always_ff @(posedge i_mclk) begin
    for (int c = 0; c < STC_CORES; c++) begin
      if (!i_reset_n) cnt_ff[c] <= 8'h0;
      else if (i_req[c] == {1'b1, STC_KIND_ORD} && i_ready[c]) cnt_ff[c] <= i_dly;
      else if (cnt_ff[c] != 8'h0) cnt_ff[c] <= cnt_ff[c] - 8'h1;
    end
  end
  // A slow core is already busy when its ordered read shows up. The hold-back
  // applies only while the read can be taken, so a queued second read that
  // stands during the wait cannot stall retirement for ever.
  // Only ordered reads wait on retired older work; unordered reads never look at it.
  always_comb begin
    for (int c = 0; c < STC_CORES; c++)
      o_retired[c] = !(cnt_ff[c] != 8'h0 ||
                       (i_dly != 8'h0 && i_ready[c] && i_req[c] == {1'b1, STC_KIND_ORD}));
  end
endmodule

// ---- test/stc_top_bench.sv ----
// Purpose: Self-checking bench for the time stamp counter.
// Assumes: All cores read together after a common load.
// Notes:   Slow ordered reads check kind and core only.
`timescale 1ns/100ps
module stc_top_bench
  import stc_pkg::*;
;
  // ==========================================================
  // Stimulus and scoreboard
  logic        clk, rst_n, scale;
  logic [7:0]  dly;
  stc_req_t    req [STC_CORES];
  logic        ret [STC_CORES];
  logic        rdy [STC_CORES];
  stc_wr_t     wr  [STC_CORES];
  stc_rsp_t    rsp [STC_CORES];
  stc_rsp_t    exp_q [STC_CORES][$];
  bit          chk_q [STC_CORES][$];
  logic [63:0] v [STC_CORES];
  logic [31:0] rs = 32'h5da3ede5;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t_q [$];
  stc_top dut_u (.i_mclk(clk), .i_reset_n(rst_n), .i_counter_freq_scale_select(scale),
    .i_req(req), .i_older_retired(ret), .o_req_ready(rdy), .i_wr(wr), .o_rsp(rsp));
  stc_core_model core_u (.i_mclk(clk), .i_reset_n(rst_n), .i_dly(dly), .i_req(req),
    .i_ready(rdy), .o_retired(ret));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic cmp(stc_rsp_t e, stc_rsp_t g, bit cv);
    n_compared++;
    if (cv ? g !== e : {g.kind, g.core_id} !== {e.kind, e.core_id}) begin
      miscompares++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_n(logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic note(int c, stc_kind_t k, logic [63:0] n, bit cv);
    if (k == STC_KIND_CAP) n = 64'h0000_0100_0000_0000;
    exp_q[c].push_back('{1'b1, k, n[63:32], n[31:0], k == STC_KIND_ORD ? 8'(c) : 8'h0});
    chk_q[c].push_back(cv);
  endtask
  task automatic rd(int c, stc_kind_t k, int n);
    req[c] = '{1'b1, k};
    while (n > 0) begin
      if (rdy[c] === 1'b1) n--;
      @(negedge clk);
    end
    req[c] = '0;
  endtask
  task automatic burst(stc_kind_t k, int n, bit cv);
    for (int c = 0; c < STC_CORES; c++) begin
      for (int i = 0; i < n; i++) note(c, k, v[c] + 64'(i), cv);
      wr[c] = '{1'b1, v[c]};
    end
    @(negedge clk);
    for (int c = 0; c < STC_CORES; c++) wr[c] = '0;
    fork
      rd(0, k, n);
      rd(1, k, n);
      rd(2, k, n);
      rd(3, k, n);
    join
    repeat (40) @(negedge clk);
    $display("test kind %0d done", k);
  endtask
  always @(posedge clk) begin
    cyc++;
    #1;
    for (int c = 0; c < STC_CORES; c++) begin
      if (rsp[c].valid === 1'b1) begin
        if (c == 0) t_q.push_back(cyc);
        if (exp_q[c].size() == 0) cmp('0, rsp[c], 1'b1);
        else cmp(exp_q[c].pop_front(), rsp[c], chk_q[c].pop_front());
      end
    end
  end
  task automatic final_report();
    for (int c = 0; c < STC_CORES; c++) miscompares += exp_q[c].size();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {scale, rst_n, dly} = {1'b1, 1'b0, 8'h0};
    for (int c = 0; c < STC_CORES; c++) begin
      req[c] = '0;
      wr[c] = '0;
      v[c] = {xs(), xs()};
    end
    v[2] = '1;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    burst(STC_KIND_UNORD, 3, 1'b1);
    burst(STC_KIND_ORD, 2, 1'b1);
    dly = 8'h5;
    burst(STC_KIND_ORD, 1, 1'b0);
    dly = 8'h0;
    burst(STC_KIND_CAP, 2, 1'b1);
    scale = 1'b0;
    t_q = {};
    burst(STC_KIND_UNORD, 3, 1'b1);
    cmp_n(STC_REF_DIV_CYC, 32'(t_q[2] - t_q[1]));
    dly = 8'h5;
    burst(STC_KIND_ORD, 2, 1'b0);
    final_report();
  end
  // The run needs under 600 cycles, so this span means a hang.
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule
